// [core/capture_compare_array.v]
`timescale 1ns/1ns
`include "capcom_defs.vh"
// Overview of operation
// - Sixteen channels, one-clock resolution, eight staggered
// - Two 16-bit time-base timers with reloads
// - Timer input: prescaled clock or external overflow
// - Timer may count external count input pulses
// - Each channel picks timer and capture/compare
// - One pin per channel, input or output
// - Capture latches assigned timer on pin event
// - Capture raises that channel's interrupt
// - Capture edge: rising, falling or both
// - Compare modes match timer on every count
// - Mode zero: interrupt each match, pin untouched
// - Mode one: pin toggles each match
// - Mode two: one interrupt per period
// - Mode three: set on match, clear overflow
// - Double mode: register pair toggles one pin
// - Single event: one compare match then stop
module capture_compare_array
#(
   parameter NCH = 16
)
(
   input  wire                mclk,
   input  wire                rstn,
   input  wire [11:0]         s_axi_awaddr,
   input  wire                s_axi_awvalid,
   output wire                s_axi_awready,
   input  wire [31:0]         s_axi_wdata,
   input  wire [3:0]          s_axi_wstrb,
   input  wire                s_axi_wvalid,
   output wire                s_axi_wready,
   output reg  [1:0]          s_axi_bresp,
   output reg                 s_axi_bvalid,
   input  wire                s_axi_bready,
   input  wire [11:0]         s_axi_araddr,
   input  wire                s_axi_arvalid,
   output wire                s_axi_arready,
   output reg  [31:0]         s_axi_rdata,
   output reg  [1:0]          s_axi_rresp,
   output reg                 s_axi_rvalid,
   input  wire                s_axi_rready,
   input  wire [NCH-1:0]      cc_pin_in,
   output reg  [NCH-1:0]      cc_pin_out,
   output reg  [NCH-1:0]      cc_pin_oe,
   input  wire                ext_overflow_pulse,
   input  wire                ext_count_in,
   output reg  [NCH-1:0]      chan_irq,
   output reg                 irq
);
   // Registers
   reg  [8:0]     tcon [0:1];
   reg  [15:0]    trel [0:1];
   reg  [15:0]    tval [0:1];
   reg  [7:0]     chctl [0:NCH-1];
   reg  [15:0]    cval [0:NCH-1];
   reg  [NCH-1:0] irq_stat;
   reg  [NCH-1:0] irq_mask;
   reg  [NCH-1:0] armed;
   reg  [NCH-1:0] done;
   reg  [NCH-1:0] pin_s1;
   reg  [NCH-1:0] pin_s2;
   reg  [NCH-1:0] pin_d;
   reg  [2:0]     cnt_s;
   reg  [5:0]     prescale;
   reg  [2:0]     stagger;
   wire [1:0]     ovf;
   wire [1:0]     tick;
   wire [NCH-1:0] hit;
   wire [NCH-1:0] ev;

   // AXI write path, both address and data held until both present
   wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign s_axi_arready = ~s_axi_rvalid;
   wire rd_go = s_axi_arvalid & ~s_axi_rvalid;

   function is_ch;
      input [11:0] a;
      input [11:0] base;
      begin
         is_ch = (a[11:6] == base[11:6]) && (a[1:0] == 2'h0);
      end
   endfunction

   wire [3:0] wch = s_axi_awaddr[5:2];
   wire [3:0] rch = s_axi_araddr[5:2];
   wire       wr_full = (s_axi_wstrb == 4'hF);
   wire       w_tcon  = wr_go && s_axi_awaddr == `A_TCON;
   wire       w_trel0 = wr_go && s_axi_awaddr == `A_TREL0;
   wire       w_trel1 = wr_go && s_axi_awaddr == `A_TREL1;
   wire       w_stat  = wr_go && s_axi_awaddr == `A_IRQ_STAT;
   wire       w_mask  = wr_go && s_axi_awaddr == `A_IRQ_MASK;
   wire       w_ch    = wr_go && is_ch(s_axi_awaddr, `A_CH_BASE);
   wire       w_cv    = wr_go && is_ch(s_axi_awaddr, `A_CV_BASE);
   wire       w_ok    = w_tcon | w_trel0 | w_trel1 | w_stat | w_mask | w_ch | w_cv;

   always @(posedge mclk)
   begin
      if (!rstn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
      end
      else if (wr_go)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= w_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   always @(posedge mclk)
   begin
      if (!rstn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= `RESP_OKAY;
      end
      else if (rd_go)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `RESP_OKAY;
         if (s_axi_araddr == `A_TCON)
            s_axi_rdata <= {23'h0, tcon[0][`TCON_STAG], tcon[1][3:0], tcon[0][3:0]};
         else if (s_axi_araddr == `A_TREL0)
            s_axi_rdata <= {16'h0, trel[0]};
         else if (s_axi_araddr == `A_TREL1)
            s_axi_rdata <= {16'h0, trel[1]};
         else if (s_axi_araddr == `A_TVAL0)
            s_axi_rdata <= {16'h0, tval[0]};
         else if (s_axi_araddr == `A_TVAL1)
            s_axi_rdata <= {16'h0, tval[1]};
         else if (s_axi_araddr == `A_IRQ_STAT)
            s_axi_rdata <= {16'h0, irq_stat};
         else if (s_axi_araddr == `A_IRQ_MASK)
            s_axi_rdata <= {16'h0, irq_mask};
         else if (is_ch(s_axi_araddr, `A_CH_BASE))
            s_axi_rdata <= {24'h0, chctl[rch]};
         else if (is_ch(s_axi_araddr, `A_CV_BASE))
            s_axi_rdata <= {16'h0, cval[rch]};
         else
         begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `RESP_SLVERR;
         end
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // Pin and count input synchronisers
   always @(posedge mclk)
   begin
      if (!rstn)
      begin
         pin_s1 <= {NCH{1'b0}};
         pin_s2 <= {NCH{1'b0}};
         pin_d  <= {NCH{1'b0}};
         cnt_s  <= 3'h0;
      end
      else
      begin
         pin_s1 <= cc_pin_in;
         pin_s2 <= pin_s1;
         pin_d  <= pin_s2;
         cnt_s  <= {cnt_s[1], cnt_s[0], ext_count_in};
      end
   end

   // Prescaler and staggered-mode divide by eight
   always @(posedge mclk)
   begin
      if (!rstn)
      begin
         prescale <= 6'h00;
         stagger  <= 3'h0;
      end
      else
      begin
         prescale <= prescale + 6'h01;
         stagger  <= stagger + 3'h1;
      end
   end

   genvar t;
   generate
      for (t = 0; t < 2; t = t + 1)
      begin : g_tmr
         wire [2:0] src = tcon[t][`TCON_SRC_HI:`TCON_SRC_LO];
         wire       stag_ok = ~tcon[t][`TCON_STAG] | (stagger == `STAG_LAST);
         reg        pre;
         wire       src_clk;
         wire       src_ovf;
         wire       src_cnt;
         // Divide by 4, 16 or 64 off one free-running counter
         always @*
         begin
            case (src[1:0])
               2'h0:    pre = 1'b1;
               2'h1:    pre = (prescale[1:0] == 2'h3);
               2'h2:    pre = (prescale[3:0] == 4'hF);
               default: pre = (prescale[5:0] == 6'h3F);
            endcase
         end
         assign src_clk = ~src[2] & pre;
         assign src_ovf = (src == `SRC_EXT_OVF) & ext_overflow_pulse;
         assign src_cnt = (src == `SRC_EXT_CNT) & cnt_s[1] & ~cnt_s[2];
         assign tick[t] = (src_clk | src_ovf | src_cnt) & tcon[t][`TCON_RUN] & stag_ok;
         assign ovf[t]  = tick[t] & (tval[t] == 16'hFFFF);
         always @(posedge mclk)
         begin
            if (!rstn)
            begin
               tval[t] <= 16'h0;
               tcon[t] <= 9'h0;
               trel[t] <= 16'h0;
            end
            else
            begin
               if (ovf[t])
                  tval[t] <= trel[t];
               else if (tick[t])
                  tval[t] <= tval[t] + 16'h1;
               if (w_tcon && wr_full)
                  tcon[t] <= {s_axi_wdata[8], 4'h0, s_axi_wdata[t*4 +: 4]};
               if ((t == 0 ? w_trel0 : w_trel1) && wr_full)
                  trel[t] <= s_axi_wdata[15:0];
            end
         end
      end
   endgenerate

   genvar c;
   generate
      for (c = 0; c < NCH; c = c + 1)
      begin : g_ch
         wire       ts    = chctl[c][`CHCTL_TSEL];
         wire [2:0] md    = chctl[c][`CHCTL_MODE_HI:`CHCTL_MODE_LO];
         wire [1:0] eg    = chctl[c][`CHCTL_EDGE_HI:`CHCTL_EDGE_LO];
         wire       rise  = pin_s2[c] & ~pin_d[c];
         wire       fall  = ~pin_s2[c] & pin_d[c];
         wire       cap   = (md == `M_CAP) && ((eg[0] & rise) | (eg[1] & fall));
         wire       cmp   = md >= `M_CMP0;
         wire       once  = (md == `M_CMP2) || (md == `M_CMP3);
         wire       pair  = (c % 2 == 1) && chctl[c][`CHCTL_DOUBLE] && (chctl[c-(c%2)][`CHCTL_MODE_HI:`CHCTL_MODE_LO] >= `M_CMP0);
         // Next count is the reload value on overflow
         wire       due   = (ovf[ts] ? trel[ts] : tval[ts] + 16'h1) == cval[c];
         // Match on the count edge only, so a stopped timer never fires
         assign hit[c] = cmp && tick[ts] && !done[c] && (!once || armed[c]) && due;
         assign ev[c]  = hit[c] | cap;
         always @(posedge mclk)
         begin
            if (!rstn)
            begin
               chctl[c]      <= 8'h0;
               cval[c]       <= 16'h0;
               armed[c]      <= 1'b1;
               done[c]       <= 1'b0;
               cc_pin_out[c] <= 1'b0;
               cc_pin_oe[c]  <= 1'b0;
               chan_irq[c]   <= 1'b0;
               irq_stat[c]   <= 1'b0;
               irq_mask[c]   <= 1'b0;
            end
            else
            begin
               chan_irq[c] <= ev[c];
               if (w_ch && wch == c && wr_full)
               begin
                  chctl[c] <= s_axi_wdata[7:0];
                  done[c]  <= 1'b0;
               end
               else if (hit[c] && chctl[c][`CHCTL_SINGLE])
                  done[c] <= 1'b1;
               if (cap)
                  cval[c] <= tval[ts];
               else if (w_cv && wch == c && wr_full)
                  cval[c] <= s_axi_wdata[15:0];
               if (ovf[ts])
                  armed[c] <= 1'b1;
               else if (hit[c] && once)
                  armed[c] <= 1'b0;
               cc_pin_oe[c] <= (md == `M_CMP1) || (md == `M_CMP3) || pair;
               if (pair)
               begin
                  if (hit[c] ^ hit[c-(c%2)])
                     cc_pin_out[c] <= ~cc_pin_out[c];
               end
               else if (md == `M_CMP1 && hit[c])
                  cc_pin_out[c] <= ~cc_pin_out[c];
               else if (md == `M_CMP3 && hit[c])
                  cc_pin_out[c] <= 1'b1;
               else if (md == `M_CMP3 && ovf[ts])
                  cc_pin_out[c] <= 1'b0;
               // Set beats write-one-to-clear
               if (ev[c])
                  irq_stat[c] <= 1'b1;
               else if (w_stat && s_axi_wstrb[c/8] && s_axi_wdata[c])
                  irq_stat[c] <= 1'b0;
               if (w_mask && s_axi_wstrb[c/8])
                  irq_mask[c] <= s_axi_wdata[c];
            end
         end
      end
   endgenerate

   always @(posedge mclk)
   begin
      if (!rstn)
         irq <= 1'b0;
      else
         irq <= |(irq_stat & irq_mask);
   end
endmodule

// [include/capcom_defs.vh]
`ifndef CAPCOM_DEFS_VH
`define CAPCOM_DEFS_VH
`define A_TCON     12'h000
`define A_TREL0    12'h004
`define A_TREL1    12'h008
`define A_TVAL0    12'h00C
`define A_TVAL1    12'h010
`define A_IRQ_STAT 12'h014
`define A_IRQ_MASK 12'h018
`define A_CH_BASE  12'h100
`define A_CV_BASE  12'h180
`define CHCTL_TSEL 0
`define CHCTL_MODE_LO 1
`define CHCTL_MODE_HI 3
`define CHCTL_SINGLE 4
`define CHCTL_DOUBLE 5
`define CHCTL_EDGE_LO 6
`define CHCTL_EDGE_HI 7
`define M_OFF  3'h0
`define M_CAP  3'h1
`define M_CMP0 3'h2
`define M_CMP1 3'h3
`define M_CMP2 3'h4
`define M_CMP3 3'h5
`define TCON_RUN 0
`define TCON_SRC_LO 1
`define TCON_SRC_HI 3
`define TCON_STAG 8
`define STAG_LAST 3'h7
`define SRC_EXT_OVF 3'h4
`define SRC_EXT_CNT 3'h5
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// [dv/capcom_monitor.sv]
`timescale 1ns/1ns
module capcom_monitor
#(
   parameter NCH = 16
)
(
   input logic           mclk,
   input logic           rstn,
   input logic           s_axi_awvalid,
   input logic           s_axi_awready,
   input logic           s_axi_wvalid,
   input logic           s_axi_wready,
   input logic           s_axi_bvalid,
   input logic           s_axi_bready,
   input logic [11:0]    s_axi_araddr,
   input logic           s_axi_arvalid,
   input logic           s_axi_arready,
   input logic [31:0]    s_axi_rdata,
   input logic [1:0]     s_axi_rresp,
   input logic           s_axi_rvalid,
   input logic           s_axi_rready,
   input logic [NCH-1:0] cc_pin_oe,
   input logic [NCH-1:0] chan_irq,
   input logic           irq
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   property p_b_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
   endproperty
   a_b_take: assert property (p_b_take) else $error("write not answered");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   property p_b_drop;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_b_drop: assert property (p_b_drop) else $error("write answer repeated");
   property p_no_b;
      !s_axi_bvalid && !s_axi_awvalid |=> !s_axi_bvalid;
   endproperty
   a_no_b: assert property (p_no_b) else $error("unasked write answer");
   property p_r_take;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_take: assert property (p_r_take) else $error("read not answered");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer unstable");
   property p_unmapped;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'hFFC |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read accepted");
   // Reset must win over the default disable
   property p_rst;
      disable iff (1'b0) !rstn |=> chan_irq == '0 && cc_pin_oe == '0 && !irq;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs live in reset");
   cover property (s_axi_bvalid && s_axi_bready);
   cover property (|chan_irq);
   cover property (irq);
endmodule
bind capture_compare_array capcom_monitor #(.NCH(NCH)) u_mon
(
   .mclk, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .s_axi_rready, .cc_pin_oe, .chan_irq, .irq
);

// [dv/pin_model.sv]
`timescale 1ns/1ns
module pin_model
(
   input  logic        mclk,
   output logic [15:0] cc_pin_in,
   output logic        ext_count_in
);
   initial cc_pin_in = 16'h0000;
   initial ext_count_in = 1'b0;
   // Level held long enough for sync and edge detect
   task drive(input int ch, input logic lv);
      @(posedge mclk);
      cc_pin_in[ch] <= lv;
      repeat (8) @(posedge mclk);
   endtask
   // One count edge, wide enough to pass the synchroniser
   task count_edge;
      @(posedge mclk);
      ext_count_in <= 1'b1;
      repeat (4) @(posedge mclk);
      ext_count_in <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask
endmodule

// [dv/capture_compare_array_tb.sv]
`timescale 1ns/1ns
`include "capcom_defs.vh"
module capture_compare_array_tb;
   logic        mclk = 1'b0;
   logic        rstn = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000;
   logic [11:0] s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h00000000;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   logic        ext_overflow_pulse = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ext_count_in, irq;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [31:0] s_axi_rdata, d, v;
   logic [15:0] cc_pin_in, cc_pin_out, cc_pin_oe, chan_irq;
   logic [15:0] last = 16'h0000;
   int          fail_count = 0;
   int          n_compared = 0;
   int          ev [16] = '{default: 0};
   int          tg [16] = '{default: 0};
   int          e0 [16];
   int          t0 [16];
   localparam logic [31:0] CTL [2:12] = '{32'h04, 32'h06, 32'h08, 32'h0A, 32'h14, 32'h00, 32'h06, 32'h26,
                                          32'h09, 32'h05, 32'h0B};
   always #5 mclk = ~mclk;
   capture_compare_array DUT
   (
      .mclk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .cc_pin_in, .cc_pin_out, .cc_pin_oe, .ext_overflow_pulse, .ext_count_in, .chan_irq, .irq
   );
   pin_model pins (.mclk, .cc_pin_in, .ext_count_in);
   always @(posedge mclk)
   begin
      last <= cc_pin_out;
      for (int i = 0; i < 16; i++)
      begin
         ev[i] <= ev[i] + chan_irq[i];
         tg[i] <= tg[i] + (cc_pin_out[i] != last[i]);
      end
   end
   task automatic wr(input logic [11:0] a, input logic [31:0] wd);
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= wd;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do @(posedge mclk); while (!(s_axi_awready && s_axi_wready));
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do @(posedge mclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      r = s_axi_bresp;
   endtask
   task automatic pulse;
      @(posedge mclk);
      ext_overflow_pulse <= 1'b1;
      @(posedge mclk);
      ext_overflow_pulse <= 1'b0;
   endtask
   // Timer one counts over exactly 80 edges between the two control writes
   task automatic span(input logic [31:0] cfg);
      rd(`A_TVAL1);
      v = d;
      wr(`A_TCON, cfg);
      repeat (77) @(posedge mclk);
      wr(`A_TCON, 32'h00000000);
      rd(`A_TVAL1);
      v = d - v;
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge mclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge mclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error at %0t: expected %h got %h", $time, exp, got);
      end
   endtask
   task automatic give_verdict;
      $display("compared %0d mismatched %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      repeat (90000) @(posedge mclk);
      fail_count++;
      give_verdict();
   end
   initial
   begin
      repeat (16) @(posedge mclk);
      rstn <= 1'b1;
      rd(12'hFFC);
      chk(32'h2, {30'h0, r});
      chk(32'h0, d);
      wr(12'hFFC, 32'h00000000);
      chk(32'h2, {30'h0, r});
      $display("test map done");
      wr(`A_TCON, 32'h1);
      repeat (20) @(posedge mclk);
      wr(`A_TCON, 32'h0);
      rd(`A_TVAL0);
      v = d;
      wr(`A_CH_BASE, 32'h42);
      pins.drive(0, 1'b1);
      rd(`A_CV_BASE);
      chk(v, d);
      chk(1, ev[0]);
      pins.drive(0, 1'b0);
      chk(1, ev[0]);
      wr(`A_CH_BASE, 32'hC2);
      pins.drive(0, 1'b1);
      pins.drive(0, 1'b0);
      chk(3, ev[0]);
      chk(0, irq);
      wr(`A_IRQ_MASK, 32'h1);
      repeat (2) @(posedge mclk);
      chk(1, irq);
      rd(`A_IRQ_STAT);
      chk(32'h1, d);
      wr(`A_IRQ_STAT, 32'h1);
      repeat (2) @(posedge mclk);
      chk(0, irq);
      $display("test capture done");
      wr(`A_TREL0, 32'hFFE0);
      for (int i = 2; i < 10; i++)
      begin
         wr(12'(`A_CV_BASE + 4 * i), (i == 9) ? 32'hFFF8 : 32'hFFF0);
         wr(12'(`A_CH_BASE + 4 * i), CTL[i]);
      end
      wr(`A_TCON, 32'h1);
      while (tg[3] < 2) @(posedge mclk);
      e0 = ev;
      t0 = tg;
      // Four reload periods of 32 counts
      repeat (128) @(posedge mclk);
      chk(4, ev[2] - e0[2]);
      chk(4, tg[3] - t0[3]);
      chk(4, ev[4] - e0[4]);
      chk(8, tg[5] - t0[5]);
      chk(8, tg[9] - t0[9]);
      chk(1, ev[6]);
      chk(32'h0228, {16'h0, cc_pin_oe & 16'h0228});
      rd(`A_TVAL0);
      chk(1, d >= 32'hFFE0);
      $display("test compare done");
      wr(`A_TCON, 32'h00000090);
      rd(`A_TCON);
      chk(32'h00000090, d);
      for (int i = 10; i < 13; i++)
      begin
         wr(12'(`A_CV_BASE + 4 * i), 32'h00000002);
         wr(12'(`A_CH_BASE + 4 * i), CTL[i]);
      end
      repeat (2) pulse();
      for (int i = 10; i < 13; i++)
         wr(12'(`A_CV_BASE + 4 * i), 32'h00000004);
      repeat (2) pulse();
      rd(`A_TVAL1);
      chk(32'h00000004, d);
      chk(32'h00000001, ev[10]);
      chk(32'h00000002, ev[11]);
      chk(32'h00000001, ev[12]);
      wr(`A_TCON, 32'h000000B0);
      repeat (3) pins.count_edge();
      rd(`A_TVAL1);
      chk(32'h00000007, d);
      span(32'h00000110);
      chk(32'h0000000A, v);
      span(32'h00000030);
      chk(32'h00000014, v);
      $display("test timer done");
      give_verdict();
   end
endmodule
